// ### rtl/fsl_pkg.sv
// package: offsets, field layouts and types for the flash security/option loader
package fsl_pkg;
	// nonvolatile area addresses (16-bit map)
	localparam logic [15:0] NV_KEY_ADDR = 16'hFFB0;
	localparam logic [15:0] NV_PROT_ADDR = 16'hFFBD;
	localparam logic [15:0] NV_OPT_ADDR = 16'hFFBF;
	// avalon register byte offsets
	localparam logic [7:0] REG_PROT_OFS = 8'h00;
	localparam logic [7:0] REG_OPT_OFS = 8'h04;
	localparam logic [7:0] REG_STAT_OFS = 8'h08;
	localparam logic [7:0] REG_KEYLO_OFS = 8'h0C;
	localparam logic [7:0] REG_KEYHI_OFS = 8'h10;
	localparam logic [7:0] REG_CTRL_OFS = 8'h14;
	// option byte fields
	localparam int OPT_BACKDOOR_KEY_ENABLE_BIT = 7;
	localparam int OPT_SEC_LSB = 0;
	localparam logic [1:0] SEC_UNSECURED = 2'h2;
	// reset values: secured, block protection off
	localparam logic [7:0] PROT_RESET = 8'hFF;
	localparam logic [7:0] OPT_RESET = 8'hFF;
	// status bits
	localparam int STAT_SECURE_BIT = 0;
	localparam int STAT_KEY_OK_BIT = 1;
	localparam int STAT_ERASED_BIT = 2;
	localparam int STAT_LOADED_BIT = 3;
	localparam int STAT_KEY_FAIL_BIT = 4;
	// ctrl bits
	localparam int CTRL_KEY_GO_BIT = 0;
	// unmapped read value
	localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

	typedef enum logic [2:0] {
		FSL_LD_IDLE = 3'b000,
		FSL_LD_PROT = 3'b001,
		FSL_LD_OPT = 3'b010,
		FSL_LD_KEY = 3'b011,
		FSL_LD_DONE = 3'b100
	} fsl_ld_e;

	// one memory access request at the gate
	typedef struct packed {
		logic req;
		logic background_debug_mode;
		logic from_secure;
		logic is_ram;
	} fsl_acc_s;
endpackage

// ### rtl/fsl_loader.sv
// flash security and option loader with avalon-mm register slave
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// [R1] every reset reloads stored protect and option bytes into working copies
// [R2] key enable one lets the 8-byte stored key unsecure until next reset
// [R3] key entry accepted only from secure code, never from background debug
// [R4] key enable zero disables key comparison entirely
// [R5] without key, only mass erase plus passing blank check unsecures
// [R6] security field value 1:0 means unsecured
// [R7] ram contents kept through wait and both stop modes
// [R8] resets leave ram untouched; power-on ram contents undefined
// [R9] while secured, block ram access by background debug or non-secure code
// [R10] any other field value, including erased byte, means secured
module fsl_loader #(
	parameter int NV_WIDTH = 8
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	// nonvolatile area read port
	output logic [15:0] nv_addr_out,
	output logic nv_rd_out,
	input wire logic [NV_WIDTH-1:0] nv_data_in,
	input wire logic nv_valid_in,
	// flash engine results
	input wire logic mass_erase_done_in,
	input wire logic blank_ok_in,
	// access gate
	input wire fsl_pkg::fsl_acc_s acc_in,
	input wire logic exec_secure_in,
	input wire logic bdm_active_in,
	output logic acc_grant_out,
	output logic acc_deny_out,
	output logic secure_out,
	output logic [7:0] block_protect_out,
	// avalon-mm slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	// ==========================================================
	// state
	// ==========================================================
	fsl_pkg::fsl_ld_e ld_state_r;
	logic [2:0] key_idx_r;
	logic [7:0] block_protect_working_r;
	logic [7:0] security_options_working_r;
	logic [63:0] backdoor_compare_key_r;
	logic [63:0] key_entry_r;
	logic key_unsecured_r;
	logic erase_seen_r;
	logic erase_unsecured_r;
	logic key_fail_r;
	logic key_go;
	logic secure_now;
	logic key_en;
	logic loaded;
	logic secured;
	logic [31:0] stat_word;
	logic rd_ack_r;
	logic wr_ack_r;

	assign key_en = security_options_working_r[fsl_pkg::OPT_BACKDOOR_KEY_ENABLE_BIT];
	assign loaded = (ld_state_r == fsl_pkg::FSL_LD_DONE);
	// only exact 1:0 is unsecured; erased ff or others stay secured
	assign secure_now = (security_options_working_r[fsl_pkg::OPT_SEC_LSB +: 2]
		!= fsl_pkg::SEC_UNSECURED) && !key_unsecured_r && !erase_unsecured_r; // [R6] [R10]
	// held secured until the whole nonvolatile load is in
	assign secured = secure_now || !loaded; // [R10]

	// ==========================================================
	// reset loader
	// ==========================================================
	// sequencer: protect byte, option byte, then eight key bytes
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ld_state_r <= fsl_pkg::FSL_LD_IDLE;
		end else begin
			case (ld_state_r)
				fsl_pkg::FSL_LD_IDLE: begin
					ld_state_r <= fsl_pkg::FSL_LD_PROT;
				end
				fsl_pkg::FSL_LD_PROT: begin
					if (nv_valid_in) begin
						ld_state_r <= fsl_pkg::FSL_LD_OPT;
					end
				end
				fsl_pkg::FSL_LD_OPT: begin
					if (nv_valid_in) begin
						ld_state_r <= fsl_pkg::FSL_LD_KEY;
					end
				end
				fsl_pkg::FSL_LD_KEY: begin
					if (nv_valid_in && key_idx_r == 3'h7) begin
						ld_state_r <= fsl_pkg::FSL_LD_DONE;
					end
				end
				fsl_pkg::FSL_LD_DONE: begin
					ld_state_r <= fsl_pkg::FSL_LD_DONE;
				end
				default: begin
					ld_state_r <= fsl_pkg::FSL_LD_IDLE;
				end
			endcase
		end
	end

	// key byte index, one step per key byte taken
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			key_idx_r <= 3'h0;
		end else if (ld_state_r == fsl_pkg::FSL_LD_KEY && nv_valid_in) begin
			key_idx_r <= key_idx_r + 3'h1;
		end
	end

	// working copies of protect and option bytes
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			block_protect_working_r <= fsl_pkg::PROT_RESET;
			security_options_working_r <= fsl_pkg::OPT_RESET; // [R10]
		end else if (nv_valid_in) begin
			if (ld_state_r == fsl_pkg::FSL_LD_PROT) begin
				block_protect_working_r <= nv_data_in[7:0]; // [R1]
			end
			if (ld_state_r == fsl_pkg::FSL_LD_OPT) begin
				security_options_working_r <= nv_data_in[7:0]; // [R1]
			end
		end
	end

	// stored comparison key, byte i at bits 8i
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			backdoor_compare_key_r <= 64'h0;
		end else if (ld_state_r == fsl_pkg::FSL_LD_KEY && nv_valid_in) begin
			backdoor_compare_key_r[key_idx_r*8 +: 8] <= nv_data_in[7:0]; // [R2]
		end
	end

	// nonvolatile read address, registered
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			nv_addr_out <= 16'h0000;
			nv_rd_out <= 1'b0;
		end else begin
			case (ld_state_r)
				fsl_pkg::FSL_LD_IDLE: begin
					nv_addr_out <= fsl_pkg::NV_PROT_ADDR;
					nv_rd_out <= 1'b1;
				end
				fsl_pkg::FSL_LD_PROT: begin
					if (nv_valid_in) begin
						nv_addr_out <= fsl_pkg::NV_OPT_ADDR;
					end
				end
				fsl_pkg::FSL_LD_OPT: begin
					if (nv_valid_in) begin
						nv_addr_out <= fsl_pkg::NV_KEY_ADDR;
					end
				end
				fsl_pkg::FSL_LD_KEY: begin
					if (nv_valid_in) begin
						nv_addr_out <= fsl_pkg::NV_KEY_ADDR + {13'h0, key_idx_r + 3'h1};
						if (key_idx_r == 3'h7) begin
							nv_rd_out <= 1'b0;
						end
					end
				end
				default: begin
					nv_rd_out <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// backdoor key and erase unsecure
	// ==========================================================
	// key trigger: bus write to ctrl from secure code, not debug
	assign key_go = wr_ack_r && (avs_address == fsl_pkg::REG_CTRL_OFS)
		&& avs_writedata[fsl_pkg::CTRL_KEY_GO_BIT] && avs_byteenable[0]
		&& exec_secure_in && !bdm_active_in; // [R3]

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			key_unsecured_r <= 1'b0;
			key_fail_r <= 1'b0;
		end else if (key_go && loaded) begin
			if (key_en && (key_entry_r == backdoor_compare_key_r)) begin // [R2] [R4]
				key_unsecured_r <= 1'b1; // [R2]
			end else begin
				key_fail_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			erase_seen_r <= 1'b0;
			erase_unsecured_r <= 1'b0;
		end else begin
			if (mass_erase_done_in) begin
				erase_seen_r <= 1'b1;
			end
			if ((erase_seen_r || mass_erase_done_in) && blank_ok_in) begin
				erase_unsecured_r <= 1'b1; // [R5]
			end
		end
	end

	// ==========================================================
	// access gate
	// ==========================================================
	// ram itself is outside: this block never writes or clears it
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			secure_out <= 1'b1;
		end else begin
			secure_out <= secured; // [R6] [R10]
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			block_protect_out <= fsl_pkg::PROT_RESET;
		end else begin
			block_protect_out <= block_protect_working_r; // [R1]
		end
	end

	// decided from the registered level, so reported and enforced state agree
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			acc_grant_out <= 1'b0;
			acc_deny_out <= 1'b0;
		end else if (acc_in.req && secure_out
			&& (acc_in.background_debug_mode || !acc_in.from_secure)) begin // [R9]
			acc_grant_out <= 1'b0;
			acc_deny_out <= 1'b1;
		end else begin
			acc_grant_out <= acc_in.req; // [R7] [R8]
			acc_deny_out <= 1'b0;
		end
	end

	// ==========================================================
	// avalon-mm slave: one wait cycle, ack on second cycle
	// ==========================================================
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rd_ack_r <= 1'b0;
			wr_ack_r <= 1'b0;
		end else begin
			rd_ack_r <= avs_read && !rd_ack_r;
			wr_ack_r <= avs_write && !wr_ack_r;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read && !rd_ack_r) || (avs_write && !wr_ack_r));
		end
	end

	// key entry written only by secure non-debug code
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			key_entry_r <= 64'h0;
		end else if (wr_ack_r && exec_secure_in && !bdm_active_in) begin // [R3]
			for (int i = 0; i < 4; i++) begin
				if (avs_byteenable[i] && avs_address == fsl_pkg::REG_KEYLO_OFS) begin
					key_entry_r[i*8 +: 8] <= avs_writedata[i*8 +: 8];
				end
				if (avs_byteenable[i] && avs_address == fsl_pkg::REG_KEYHI_OFS) begin
					key_entry_r[32+i*8 +: 8] <= avs_writedata[i*8 +: 8];
				end
			end
		end
	end

	// status word from named bit positions
	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[fsl_pkg::STAT_SECURE_BIT] = secured;
		stat_word[fsl_pkg::STAT_KEY_OK_BIT] = key_unsecured_r;
		stat_word[fsl_pkg::STAT_ERASED_BIT] = erase_unsecured_r;
		stat_word[fsl_pkg::STAT_LOADED_BIT] = loaded;
		stat_word[fsl_pkg::STAT_KEY_FAIL_BIT] = key_fail_r;
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && !rd_ack_r) begin
			case (avs_address)
				fsl_pkg::REG_PROT_OFS: avs_readdata <= {24'h0, block_protect_working_r};
				fsl_pkg::REG_OPT_OFS: avs_readdata <= {24'h0, security_options_working_r};
				fsl_pkg::REG_STAT_OFS: avs_readdata <= stat_word;
				default: avs_readdata <= fsl_pkg::UNMAPPED_RD;
			endcase
		end
	end
endmodule

// ### dv/fsl_loader_properties.sv
// loader port checks
`timescale 1ns/1ps
module fsl_loader_props (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire fsl_pkg::fsl_acc_s acc_in,
	input wire logic [15:0] nv_addr_out,
	input wire logic nv_rd_out,
	input wire logic nv_valid_in,
	input wire logic avs_read,
	input wire logic avs_waitrequest,
	input wire logic acc_grant_out,
	input wire logic acc_deny_out,
	input wire logic secure_out
);
// ====
// checks
default clocking @(posedge clk_in);
endclocking
default disable iff (!nrst_in);
sequence s_lock;
	acc_in.req && acc_in.is_ram && secure_out;
endsequence
sequence s_prot;
	nv_valid_in && nv_rd_out && nv_addr_out == fsl_pkg::NV_PROT_ADDR;
endsequence
a_deny_debug: assert property (s_lock ##0 acc_in.background_debug_mode |=> acc_deny_out)
	else $error("debug not denied");
a_deny_plain: assert property (s_lock ##0 !acc_in.from_secure |=> acc_deny_out)
	else $error("plain code not denied");
a_grant_open: assert property (acc_in.req && !secure_out |=> acc_grant_out)
	else $error("open access not granted");
a_idle_quiet: assert property (!acc_in.req |=> !acc_grant_out && !acc_deny_out)
	else $error("answer without request");
a_bus_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
	else $error("read wait wrong");
a_load_locked: assert property (nv_rd_out |-> secure_out)
	else $error("open during load");
a_prot_opt: assert property (s_prot |=> nv_rd_out && nv_addr_out == fsl_pkg::NV_OPT_ADDR)
	else $error("option read not next");
a_stay_open: assert property (!secure_out |=> !secure_out)
	else $error("security came back");
endmodule

// ### dv/fsl_nv_model.sv
// nonvolatile byte store for the loader
`timescale 1ns/1ps
module fsl_nv_model (
	input wire logic clk_in,
	input wire logic rd_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0] prot_in,
	input wire logic [7:0] opt_in,
	input wire logic [63:0] key_in,
	input wire logic slow_in,
	output logic [7:0] data_out,
	output logic valid_out = 1'h0
);
// ====
// prompt or slow byte answers
logic [1:0] gap_r = 2'h0;
logic [7:0] byte_v;
always_comb begin
	byte_v = key_in[addr_in[2:0]*8 +: 8];
	if (addr_in == fsl_pkg::NV_PROT_ADDR) byte_v = prot_in;
	if (addr_in == fsl_pkg::NV_OPT_ADDR) byte_v = opt_in;
end
always @(posedge clk_in) begin
	gap_r <= (!rd_in || valid_out) ? {slow_in, 1'h1} : gap_r - {1'h0, gap_r != 2'h0};
	valid_out <= rd_in && gap_r == 2'h0 && !valid_out;
end
// no stale byte outside a valid cycle
assign data_out = valid_out ? byte_v : ~byte_v;
endmodule

// ### dv/flash_security_option_loader_tb_top.sv
// bench for the flash security option loader
`timescale 1ns/1ps
module flash_security_option_loader_tb_top;
// ====
// design, store, clock
logic clk_in = 1'h0, nrst_in = 1'h0, nv_valid_in, mass_erase_done_in = 1'h0, blank_ok_in = 1'h0;
logic exec_secure_in = 1'h0, bdm_active_in = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
logic acc_grant_out, acc_deny_out, secure_out, nv_rd_out, avs_waitrequest;
logic [3:0] avs_byteenable = 4'hF;
logic [7:0] avs_address = 8'h00, nv_data_in, block_protect_out, prot = 8'h00, opt = 8'h00;
logic [7:0] lk[4] = '{8'h80, 8'hC1, 8'h83, 8'hFF};
logic [15:0] nv_addr_out;
logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, lfsr = 32'h0407;
logic [63:0] key = 64'h0;
fsl_pkg::fsl_acc_s acc_in = '0;
int err_total = 0, tests_run = 0, cyc = 0;
fsl_loader DUT (.*);
fsl_nv_model NV (.clk_in, .rd_in(nv_rd_out), .addr_in(nv_addr_out), .prot_in(prot),
	.opt_in(opt), .key_in(key), .slow_in(lfsr[5]), .data_out(nv_data_in), .valid_out(nv_valid_in));
initial forever #4 clk_in = ~clk_in;
always @(posedge clk_in) if (++cyc == 20000) begin
	err_total++;
	finish_test();
end
// ====
// tasks
function automatic logic [31:0] rnd();
	lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
	return lfsr;
endfunction
function automatic logic locked(input logic [7:0] o);
	return o[1:0] !== fsl_pkg::SEC_UNSECURED;
endfunction
task automatic chk(input logic [31:0] g, input logic [31:0] e);
	tests_run++;
	if (g !== e) begin
		err_total++;
		$display("unexpected %0t got %h want %h", $time, g, e);
	end
endtask
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
	avs_address <= a;
	avs_writedata <= d;
	avs_write <= w;
	avs_read <= !w;
	do @(posedge clk_in); while (avs_waitrequest !== 1'h0);
	rd = avs_readdata;
	avs_read <= 1'h0;
	avs_write <= 1'h0;
	@(posedge clk_in);
endtask
task automatic gate(input logic b, input logic s, input logic [1:0] e);
	acc_in <= '{1'h1, b, s, 1'h1};
	bdm_active_in <= b;
	exec_secure_in <= s;
	@(posedge clk_in);
	@(negedge clk_in);
	chk({acc_grant_out, acc_deny_out}, e);
	@(posedge clk_in);
	acc_in <= '0;
	@(posedge clk_in);
endtask
task automatic key_try(input logic [63:0] k);
	bus(1'h1, fsl_pkg::REG_KEYLO_OFS, k[31:0]);
	bus(1'h1, fsl_pkg::REG_KEYHI_OFS, k[63:32]);
	bus(1'h1, fsl_pkg::REG_CTRL_OFS, 32'h1);
	bus(1'h0, fsl_pkg::REG_STAT_OFS);
endtask
task automatic boot(input logic [7:0] o);
	prot = 8'(rnd());
	key = {rnd(), rnd()};
	opt = o;
	nrst_in <= 1'h0;
	repeat (20) @(posedge clk_in);
	nrst_in <= 1'h1;
	do bus(1'h0, fsl_pkg::REG_STAT_OFS); while (rd[fsl_pkg::STAT_LOADED_BIT] !== 1'h1);
	chk(secure_out, locked(o));
	chk(block_protect_out, prot);
	bus(1'h0, fsl_pkg::REG_OPT_OFS);
	chk(rd, o);
endtask
task automatic finish_test();
	$display("comparisons %0d mismatches %0d", tests_run, err_total);
	if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
	else $display("CHECKS NOT OK");
	$finish;
endtask
// ====
// scenarios
initial begin
	boot({lfsr[9:4], fsl_pkg::SEC_UNSECURED});
	gate(1'h1, 1'h0, 2'h2);
	bus(1'h1, fsl_pkg::REG_PROT_OFS, ~{24'h0, prot});
	bus(1'h1, 8'h40, 32'hFFFF_FFFF);
	bus(1'h0, fsl_pkg::REG_PROT_OFS);
	chk(rd, prot);
	bus(1'h0, 8'h40);
	chk(rd, fsl_pkg::UNMAPPED_RD);
	$display("open done");
	foreach (lk[i]) begin
		boot(lk[i]);
		gate(1'h1, 1'h1, 2'h1);
		gate(1'h0, 1'h0, 2'h1);
		gate(1'h0, 1'h1, 2'h2);
	end
	$display("locked done");
	key_try(~key);
	chk(rd[fsl_pkg::STAT_KEY_FAIL_BIT], 1'h1);
	bdm_active_in <= 1'h1;
	key_try(key);
	chk(secure_out, 1'h1);
	bdm_active_in <= 1'h0;
	exec_secure_in <= 1'h0;
	key_try(key);
	chk(rd[fsl_pkg::STAT_SECURE_BIT], 1'h1);
	exec_secure_in <= 1'h1;
	key_try(key);
	chk(rd[fsl_pkg::STAT_KEY_OK_BIT], 1'h1);
	gate(1'h1, 1'h0, 2'h2);
	$display("key done");
	boot({1'h0, lfsr[8:4], 2'h1});
	exec_secure_in <= 1'h1;
	bdm_active_in <= 1'h0;
	key_try(key);
	chk(secure_out, 1'h1);
	blank_ok_in <= 1'h1;
	@(posedge clk_in);
	blank_ok_in <= 1'h0;
	bus(1'h0, fsl_pkg::REG_STAT_OFS);
	chk(rd[fsl_pkg::STAT_SECURE_BIT], 1'h1);
	mass_erase_done_in <= 1'h1;
	blank_ok_in <= 1'h1;
	@(posedge clk_in);
	mass_erase_done_in <= 1'h0;
	blank_ok_in <= 1'h0;
	bus(1'h0, fsl_pkg::REG_STAT_OFS);
	chk(rd[fsl_pkg::STAT_ERASED_BIT], 1'h1);
	chk(secure_out, 1'h0);
	$display("erase done");
	finish_test();
end
endmodule
bind fsl_loader fsl_loader_props CHK (.*);
